// >>> can_mode_pkg.sv
// Constants for the CAN mode-control and command-strobe block.
// Assumes an APB slave with 32-bit data; register bytes sit in bits 7:0.
// Overview of operation
// [RL1] Receive-interrupt enable set: error-free received message raises receive interrupt.
// [RL2] Reset request set aborts transfer in progress and enters reset mode.
// [RL3] Reset request falling from one to zero leaves reset mode.
// [RL4] Host writes zero to the top reserved control bit; it resets to zero.
// [RL5] Legacy sync-select bit stores writes, does nothing, survives every reset.
// [RL6] Third reserved control bit always reads as one.
// [RL7] Hardware reset or bus-off forces reset request to one.
// [RL8] Software reset-request writes take effect on next internal half-rate clock edge.
// [RL9] Reset pin low blocks clearing reset request; host reads back to confirm.
// [RL10] Reset-request reads return the synchronised value, not the written one.
// [RL11] After host or hardware reset, wait one bus-free before bus-on.
// [RL12] After self-caused bus-off, wait 128 bus-free conditions before bus-on.
// [RL13] Command register is write-only and reads as all ones.
// [RL14] Host leaves one internal clock cycle between two command writes.
// [RL15] Sleep only when no interrupt pending and bus idle, else wake-up interrupt.
// [RL16] After sleep entry clock output toggles 15 bit times, then held low.
// [RL17] Sleep clear, bus activity or interrupt low wakes; oscillator restarts, interrupt.
// [RL18] Woken by bus activity: no reception until 11 recessive bits seen.
// [RL19] Sleep ignored in reset mode and until bus-free seen after reset.
// [RL20] Clear-overrun clears flag; no new overrun interrupt while flag set.
// [RL21] Release frees FIFO slot; next message re-raises interrupt, else flag clears.
// [RL22] Abort cancels a pending transmit not yet started; running frame completes.
// [RL23] Writing zero to transmit request cancels nothing; only abort does.
// [RL24] Setting reset request resets receive FIFO pointers to current start.
// [RL25] Transmit request clears transmit-complete flag until a successful transmission.
// [RL26] Command bits are one-shot strobes, never stored.

package can_mode_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h00;
  localparam logic [7:0] CMD_IDX = 8'h01;
  localparam logic [7:0] STAT_IDX = 8'h02;
  localparam logic [11:0] CTRL_ADDR = 12'h000;
  localparam logic [11:0] CMD_ADDR = 12'h004;
  localparam logic [11:0] STAT_ADDR = 12'h008;

  // Control register fields
  localparam int CTRL_RR_BIT = 0;
  localparam int CTRL_RIE_BIT = 1;
  localparam int CTRL_OIE_BIT = 4;
  localparam int CTRL_ONE_BIT = 5;
  localparam int CTRL_SYNC_BIT = 6;
  localparam logic [3:0] CTRL_ENA_RESET = 4'h0;

  // Command register fields
  localparam int CMD_TR_BIT = 0;
  localparam int CMD_AT_BIT = 1;
  localparam int CMD_RRB_BIT = 2;
  localparam int CMD_CDO_BIT = 3;
  localparam int CMD_GTS_BIT = 4;
  localparam logic [7:0] CMD_READ_VALUE = 8'hFF;

  // Bus-free counts and sleep hold-off
  localparam logic [7:0] FREE_COUNT_RESET = 8'h01;
  localparam logic [7:0] FREE_COUNT_BUSOFF = 8'h80;
  localparam logic [3:0] SLEEP_CLK_BITS = 4'hF;

  typedef enum logic [1:0] {
    MODE_RESET,
    MODE_WAIT_FREE,
    MODE_ON,
    MODE_SLEEP
  } mode_t;

endpackage

// >>> can_mode_ctrl.sv
// Mode control and command strobes of a stand-alone CAN controller.
// Assumes an APB master on core_clk_i and the bit-stream, FIFO and error
// logic of the controller on the plain ports, all synchronous to core_clk_i.
`timescale 1ns/10ps

module can_mode_ctrl
  import can_mode_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Controller core
  input wire logic reset_pin_b_i,
  input wire logic bus_off_i,
  input wire logic bus_free_i,
  input wire logic bus_activity_i,
  input wire logic bit_tick_i,
  input wire logic irq_pending_i,
  input wire logic int_pin_low_i,
  input wire logic rx_msg_valid_i,
  input wire logic rx_more_i,
  input wire logic overrun_event_i,
  input wire logic tx_start_i,
  input wire logic tx_end_i,
  input wire logic tx_success_i,
  output logic reset_mode_o,
  output logic bus_on_o,
  output logic rx_enable_o,
  output logic abort_frame_o,
  output logic fifo_ptr_reset_o,
  output logic rx_release_o,
  output logic tx_go_o,
  output logic sleep_o,
  output logic osc_enable_o,
  output logic clock_output_pin_o,
  output logic receive_irq_o,
  output logic overrun_irq_o,
  output logic wakeup_irq_o
);

  // Bus decode
  logic [31:0] next_rdata;
  wire setup_ph = psel_i & ~penable_i;
  wire wr_acc = psel_i & penable_i & pwrite_i;
  wire hit_ctrl = (paddr_i == CTRL_ADDR);
  wire hit_cmd = (paddr_i == CMD_ADDR);
  wire hit_stat = (paddr_i == STAT_ADDR);
  wire mapped = hit_ctrl | hit_cmd | hit_stat;
  wire ctrl_wr = wr_acc & hit_ctrl;
  wire cmd_wr = wr_acc & hit_cmd;

  // Command strobes live for the write cycle only [RL26]
  wire cmd_tr = cmd_wr & pwdata_i[CMD_TR_BIT];
  wire cmd_at = cmd_wr & pwdata_i[CMD_AT_BIT];
  wire cmd_rrb = cmd_wr & pwdata_i[CMD_RRB_BIT];
  wire cmd_cdo = cmd_wr & pwdata_i[CMD_CDO_BIT];
  wire cmd_gts = cmd_wr & pwdata_i[CMD_GTS_BIT];
  wire cmd_wake = cmd_wr & ~pwdata_i[CMD_GTS_BIT];

  // State
  mode_t mode, next_mode;
  logic int_ce, rr, rr_wr_pend, rr_wr_val, sync_sel, busoff_cause;
  logic [3:0] ctrl_ena, sleep_bits;
  logic [7:0] free_cnt;
  logic bus_off_q, rx_block, clk_run, clk_out, tx_pending, tx_busy;
  logic tx_complete_flag, overrun_flag, rx_buffer_full_flag;
  logic rx_irq_q, ovr_irq_q, wake_irq_q, abort_q, ptr_rst_q, release_q;

  // Reset-request decisions at the internal edge
  wire receive_irq_enable = ctrl_ena[CTRL_RIE_BIT - 1];
  wire oie = ctrl_ena[CTRL_OIE_BIT - 1];
  wire bus_off_rise = bus_off_i & ~bus_off_q;
  wire rr_force = ~reset_pin_b_i | bus_off_rise; // [RL7] [RL9]
  wire rr_next_val = rr_force | (rr_wr_pend ? rr_wr_val : rr);
  wire rr_set = int_ce & rr_next_val & ~rr; // [RL2]
  wire rr_clr = int_ce & ~rr_next_val & rr; // [RL3]

  // Sleep entry and wake-up terms
  wire sleep_block = irq_pending_i | bus_activity_i;
  wire sleep_ok = cmd_gts & (mode == MODE_ON) & ~sleep_block; // [RL19]
  wire sleep_nak = cmd_gts & (mode == MODE_ON) & sleep_block; // [RL15]
  wire wake_bus = (mode == MODE_SLEEP) & bus_activity_i;
  wire wake_any = (mode == MODE_SLEEP)
    & (cmd_wake | bus_activity_i | int_pin_low_i); // [RL17]
  wire free_done = bus_free_i & (free_cnt == 8'h01);

  // Transmit status terms
  wire tx_abort = cmd_at & tx_pending & ~tx_busy; // [RL22]
  wire tx_buffer_free = ~tx_pending & ~tx_busy;
  wire tx_accept = cmd_tr & ~rr & tx_buffer_free;

  // Mode transitions; reset request has priority over everything
  always_comb
  begin
    next_mode = mode;
    unique case (mode)
      MODE_RESET:
        if (rr_clr)
          next_mode = MODE_WAIT_FREE; // [RL3]
      MODE_WAIT_FREE:
        if (rr_set)
          next_mode = MODE_RESET;
        else if (free_done)
          next_mode = MODE_ON; // [RL11] [RL12]
      MODE_ON:
        if (rr_set)
          next_mode = MODE_RESET; // [RL2]
        else if (sleep_ok)
          next_mode = MODE_SLEEP; // [RL15]
      MODE_SLEEP:
        if (rr_set)
          next_mode = MODE_RESET;
        else if (wake_any)
          next_mode = MODE_ON; // [RL17]
    endcase
  end

  // Internal clock enable at half the core rate
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      int_ce <= 1'b0;
    else
      int_ce <= ~int_ce;
  end

  // Mode register
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      mode <= MODE_RESET;
    else
      mode <= next_mode;
  end

  // Written value is held until the internal edge picks it up [RL8]
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rr <= 1'b1; // [RL7]
      rr_wr_pend <= 1'b0;
      rr_wr_val <= 1'b1;
      bus_off_q <= 1'b0;
    end
    else
    begin
      if (ctrl_wr)
      begin
        rr_wr_pend <= 1'b1;
        rr_wr_val <= pwdata_i[CTRL_RR_BIT];
      end
      else if (int_ce)
        rr_wr_pend <= 1'b0;
      if (int_ce)
      begin
        rr <= rr_next_val; // [RL8] [RL9]
        bus_off_q <= bus_off_i;
      end
    end
  end

  // Interrupt enables; top reserved bit is never stored [RL4]
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl_ena <= CTRL_ENA_RESET;
    else if (ctrl_wr)
      ctrl_ena <= pwdata_i[CTRL_OIE_BIT:CTRL_RIE_BIT];
  end

  // No reset on purpose: the legacy bit must survive every reset [RL5]
  always_ff @(posedge core_clk_i)
  begin
    if (ctrl_wr)
      sync_sel <= pwdata_i[CTRL_SYNC_BIT]; // [RL5]
  end

  // Bus-free counting; the cause of the last reset picks the count
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      busoff_cause <= 1'b0;
      free_cnt <= FREE_COUNT_RESET;
    end
    else
    begin
      if (rr_set)
        busoff_cause <= bus_off_rise & reset_pin_b_i;
      if (rr_clr)
        free_cnt <= busoff_cause ? FREE_COUNT_BUSOFF
          : FREE_COUNT_RESET; // [RL11] [RL12]
      else if (mode == MODE_WAIT_FREE && bus_free_i)
        free_cnt <= free_cnt - 8'h01;
    end
  end

  // Message that woke us is not received until bus-free [RL18]
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rx_block <= 1'b0;
    else if (wake_bus)
      rx_block <= 1'b1; // [RL18]
    else if (bus_free_i)
      rx_block <= 1'b0;
  end

  // Clock output keeps running 15 bit times into sleep [RL16]
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sleep_bits <= 4'h0;
      clk_run <= 1'b1;
    end
    else if (mode != MODE_SLEEP)
    begin
      sleep_bits <= 4'h0;
      clk_run <= 1'b1; // [RL17]
    end
    else if (bit_tick_i && clk_run)
    begin
      sleep_bits <= sleep_bits + 4'h1;
      if (sleep_bits == SLEEP_CLK_BITS) // First tick ends a partial bit
        clk_run <= 1'b0; // [RL16]
    end
  end

  // Clock output at the internal rate, parked low when stopped
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      clk_out <= 1'b0;
    else
      clk_out <= clk_run & ~clk_out;
  end

  // Transmit request bookkeeping; a written 0 leaves it alone [RL23]
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tx_pending <= 1'b0;
      tx_busy <= 1'b0;
      tx_complete_flag <= 1'b1;
    end
    else if (rr_set)
    begin
      tx_pending <= 1'b0; // [RL2]
      tx_busy <= 1'b0;
    end
    else
    begin
      if (tx_accept)
        tx_pending <= 1'b1; // [RL23]
      else if (tx_abort || tx_start_i)
        tx_pending <= 1'b0; // [RL22]
      if (tx_start_i && tx_pending)
        tx_busy <= 1'b1;
      else if (tx_end_i)
        tx_busy <= 1'b0;
      // Accept needs a free buffer, so it never meets a success end
      if (tx_accept)
        tx_complete_flag <= 1'b0; // [RL25]
      else if (tx_end_i && tx_busy && tx_success_i)
        tx_complete_flag <= 1'b1; // [RL25]
    end
  end

  // Receive and overrun flags; a hardware set beats a command clear
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      overrun_flag <= 1'b0;
      rx_buffer_full_flag <= 1'b0;
    end
    else
    begin
      if (overrun_event_i)
        overrun_flag <= 1'b1;
      else if (cmd_cdo)
        overrun_flag <= 1'b0; // [RL20]
      if (rx_msg_valid_i)
        rx_buffer_full_flag <= 1'b1;
      else if (rr_set)
        rx_buffer_full_flag <= 1'b0;
      else if (cmd_rrb && !rx_more_i)
        rx_buffer_full_flag <= 1'b0; // [RL21]
    end
  end

  // Event pulses, one cycle each
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rx_irq_q <= 1'b0;
      ovr_irq_q <= 1'b0;
      wake_irq_q <= 1'b0;
      abort_q <= 1'b0;
      ptr_rst_q <= 1'b0;
      release_q <= 1'b0;
    end
    else
    begin
      rx_irq_q <= receive_irq_enable & (rx_msg_valid_i | (cmd_rrb & rx_more_i)); // [RL1]
      ovr_irq_q <= oie & overrun_event_i & ~overrun_flag; // [RL20]
      wake_irq_q <= sleep_nak | wake_any; // [RL15] [RL17]
      abort_q <= rr_set; // [RL2]
      ptr_rst_q <= rr_set; // [RL24]
      release_q <= cmd_rrb; // [RL21]
    end
  end

  // Read mux; the command word always reads back as all ones
  wire [7:0] ctrl_rd = {1'b0, sync_sel, 1'b1, ctrl_ena, rr}; // [RL6] [RL10]
  wire [7:0] stat_rd = {1'b0, mode == MODE_SLEEP, bus_on_o, rr,
    tx_complete_flag, tx_buffer_free, overrun_flag, rx_buffer_full_flag};
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl)
      next_rdata = {24'h00_0000, ctrl_rd};
    else if (hit_cmd)
      next_rdata = {24'h00_0000, CMD_READ_VALUE}; // [RL13]
    else if (hit_stat)
      next_rdata = {24'h00_0000, stat_rd};
  end

  // Read data captured in setup so it is a flop output in access
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      prdata_o <= 32'h0000_0000;
    else if (setup_ph && !pwrite_i)
      prdata_o <= next_rdata;
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // Outputs to the controller core
  assign reset_mode_o = rr; // [RL2]
  assign bus_on_o = (mode == MODE_ON) | (mode == MODE_SLEEP);
  assign rx_enable_o = bus_on_o & ~rx_block & (mode != MODE_SLEEP);
  assign abort_frame_o = abort_q;
  assign fifo_ptr_reset_o = ptr_rst_q; // [RL24]
  assign rx_release_o = release_q;
  assign tx_go_o = tx_pending & (mode == MODE_ON);
  assign sleep_o = (mode == MODE_SLEEP);
  // Oscillator stays on until the clock output has parked low
  assign osc_enable_o = ~sleep_o | clk_run | clk_out; // [RL17]
  assign clock_output_pin_o = clk_out;
  assign receive_irq_o = rx_irq_q;
  assign overrun_irq_o = ovr_irq_q;
  assign wakeup_irq_o = wake_irq_q;

endmodule // can_mode_ctrl

// >>> can_mode_props.sv
// Assertion checker for the mode and command block.
// Sees only top-level ports; bound into can_mode_ctrl below.
`timescale 1ns/10ps
module can_mode_props
  import can_mode_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic reset_pin_b_i,
  input wire logic bus_free_i,
  input wire logic reset_mode_o,
  input wire logic bus_on_o,
  input wire logic tx_go_o,
  input wire logic abort_frame_o,
  input wire logic fifo_ptr_reset_o,
  input wire logic rx_release_o,
  input wire logic sleep_o,
  input wire logic osc_enable_o,
  input wire logic clock_output_pin_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Host accesses decoded at the access edge
  wire logic acc = psel_i && penable_i;
  wire logic wr_cmd = acc && pwrite_i && paddr_i == CMD_ADDR;
  wire logic rd_cmd = acc && !pwrite_i && paddr_i == CMD_ADDR;
  wire logic wr_ctl = acc && pwrite_i && paddr_i == CTRL_ADDR;
  wire logic rr_clr = wr_ctl && !pwdata_i[CTRL_RR_BIT];

  AST_CMD_READ: assert property (
    rd_cmd |-> prdata_o[7:0] == CMD_READ_VALUE)
    else $error("command read not all ones");
  AST_PIN_HOLD: assert property (
    !reset_pin_b_i [*3] |-> reset_mode_o)
    else $error("reset request clear while pin low");
  // Seen falling two or three samples after a clearing write
  AST_RR_SYNC: assert property (
    $fell(reset_mode_o) |-> $past(rr_clr, 2) || $past(rr_clr, 3))
    else $error("reset request fell without sync write");
  AST_ABORT: assert property (
    $rose(reset_mode_o) |-> ##[0:1] (abort_frame_o && fifo_ptr_reset_o))
    else $error("no abort or pointer reset on reset entry");
  AST_GATE: assert property (
    reset_mode_o [*2] |-> !bus_on_o && !tx_go_o && !sleep_o)
    else $error("activity while in reset mode");
  AST_BUS_ON: assert property (
    $rose(bus_on_o) |-> $past(bus_free_i) || $past(bus_free_i, 2)
      || $past(sleep_o))
    else $error("bus-on without bus-free");
  AST_RELEASE: assert property (
    rx_release_o |-> $past(wr_cmd && pwdata_i[CMD_RRB_BIT]))
    else $error("release pulse without command");
  AST_CLK_STOP: assert property (
    !osc_enable_o |-> sleep_o && !clock_output_pin_o)
    else $error("oscillator off outside stopped sleep");
endmodule // can_mode_props

bind can_mode_ctrl can_mode_props i_props (
  .core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .prdata_o, .reset_pin_b_i, .bus_free_i, .reset_mode_o,
  .bus_on_o, .tx_go_o, .abort_frame_o, .fifo_ptr_reset_o,
  .rx_release_o, .sleep_o, .osc_enable_o, .clock_output_pin_o
);

// >>> can_core_model.sv
// Core-side model: bit-time ticks and bus-free pulses on request.
// Assumes core_clk_i; a bit time here is four core cycles.
`timescale 1ns/10ps
module can_core_model (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic go_i,
  input wire logic [7:0] count_i,
  output logic bit_tick_o,
  output logic bus_free_o,
  output logic busy_o
);
  logic [1:0] div;
  logic [7:0] left;
  // Short bit time keeps sleep and bus-off runs brief
  assign bit_tick_o = div == 2'h3;
  assign busy_o = left != 8'h00;
  // One bus-free pulse per bit time until the count runs out
  always_ff @(posedge core_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      div <= 2'h0;
      left <= 8'h00;
      bus_free_o <= 1'b0;
    end
    else
    begin
      div <= div + 2'h1;
      bus_free_o <= busy_o && bit_tick_o;
      if (go_i)
        left <= count_i;
      else if (busy_o && bit_tick_o)
        left <= left - 8'h01;
    end
endmodule // can_core_model

// >>> tb.sv
// Self-checking bench for can_mode_ctrl.
// Host side is APB from here; core side from can_core_model and pulses.
`timescale 1ns/10ps
module tb;
  import can_mode_pkg::*;
  logic core_clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0;
  logic penable_i = 1'b0, pwrite_i = 1'b0, reset_pin_b_i = 1'b1;
  logic bus_off_i = 1'b0, bus_activity_i = 1'b0, irq_pending_i = 1'b0;
  logic int_pin_low_i = 1'b0, rx_more_i = 1'b0, tx_success_i = 1'b0;
  logic go = 1'b0, perr;
  logic [3:0] ev = 4'h0;
  logic [7:0] count = 8'h00;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0000_0000, rdv, prdata_o;
  logic pready_o, pslverr_o, reset_mode_o, bus_on_o, rx_enable_o;
  logic abort_frame_o, fifo_ptr_reset_o, rx_release_o, tx_go_o, sleep_o;
  logic osc_enable_o, clock_output_pin_o, receive_irq_o, overrun_irq_o;
  logic wakeup_irq_o, bus_free_i, bit_tick_i, busy;
  int fails = 0, check_count = 0, n_rx = 0, n_ov = 0, n_wk = 0, n_rel = 0;
  // Core event pulses share one vector
  wire logic rx_msg_valid_i = ev[0];
  wire logic overrun_event_i = ev[1];
  wire logic tx_start_i = ev[2];
  wire logic tx_end_i = ev[3];

  always #5 core_clk_i = ~core_clk_i;
  can_mode_ctrl i_dut (
    .core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .reset_pin_b_i,
    .bus_off_i, .bus_free_i, .bus_activity_i, .bit_tick_i,
    .irq_pending_i, .int_pin_low_i, .rx_msg_valid_i, .rx_more_i,
    .overrun_event_i, .tx_start_i, .tx_end_i, .tx_success_i,
    .reset_mode_o, .bus_on_o, .rx_enable_o, .abort_frame_o,
    .fifo_ptr_reset_o, .rx_release_o, .tx_go_o, .sleep_o,
    .osc_enable_o, .clock_output_pin_o, .receive_irq_o,
    .overrun_irq_o, .wakeup_irq_o
  );
  can_core_model i_core (
    .core_clk_i, .rst_b_i, .go_i(go), .count_i(count),
    .bit_tick_o(bit_tick_i), .bus_free_o(bus_free_i), .busy_o(busy)
  );
  // Pulse counters; one-cycle outputs are seen exactly once each
  always @(posedge core_clk_i)
  begin
    n_rx <= n_rx + (receive_irq_o === 1'b1);
    n_ov <= n_ov + (overrun_irq_o === 1'b1);
    n_wk <= n_wk + (wakeup_irq_o === 1'b1);
    n_rel <= n_rel + (rx_release_o === 1'b1);
  end

  task automatic complete_run();
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // One APB transfer; the idle tail keeps command writes apart
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [7:0] d);
    int i;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h000000, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    @(posedge core_clk_i);
    for (i = 0; i < 16 && pready_o !== 1'b1; i++)
      @(posedge core_clk_i);
    rdv = prdata_o;
    perr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (i == 16)
    begin
      fails++;
      complete_run();
    end
    cyc(4);
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge core_clk_i);
    ev <= m;
    @(posedge core_clk_i);
    ev <= 4'h0;
    cyc(3);
  endtask
  // Bus-free pulses from the core model, bounded wait
  task automatic free(input logic [7:0] n);
    int i;
    @(posedge core_clk_i);
    go <= 1'b1;
    count <= n;
    @(posedge core_clk_i);
    go <= 1'b0;
    #1;
    for (i = 0; i < 1200 && busy !== 1'b0; i++)
      @(posedge core_clk_i);
    if (i == 1200)
    begin
      fails++;
      complete_run();
    end
    cyc(3);
  endtask

  // Reset values, fixed bits, write-only command word, sleep in reset
  task automatic t_reset();
    apb(1'b0, CTRL_ADDR, 8'h00);
    chk(rdv & 32'hFFFF_FFBF, 32'h0000_0021);
    apb(1'b0, CMD_ADDR, 8'h00);
    chk(rdv, 32'h0000_00FF);
    apb(1'b0, 12'h00C, 8'h00);
    chk(perr, 1'b1);
    apb(1'b1, CMD_ADDR, 8'h10);
    chk(sleep_o, 1'b0);
  endtask
  // Leave reset; one bus-free then bus-on
  task automatic t_start();
    apb(1'b1, CTRL_ADDR, 8'h42);
    apb(1'b0, CTRL_ADDR, 8'h00);
    chk(rdv, 32'h0000_0062);
    chk(bus_on_o, 1'b0);
    free(8'h01);
    chk(bus_on_o, 1'b1);
  endtask
  // Receive interrupt enable, release with and without more data
  task automatic t_rx();
    pulse(4'h1);
    chk(n_rx, 1);
    apb(1'b1, CTRL_ADDR, 8'h50);
    pulse(4'h1);
    chk(n_rx, 1);
    apb(1'b1, CTRL_ADDR, 8'h52);
    @(posedge core_clk_i);
    rx_more_i <= 1'b1;
    apb(1'b1, CMD_ADDR, 8'h04);
    chk(n_rx, 2);
    @(posedge core_clk_i);
    rx_more_i <= 1'b0;
    apb(1'b1, CMD_ADDR, 8'h04);
    apb(1'b1, CMD_ADDR, 8'h00);
    chk(n_rx, 2);
    chk(n_rel, 2);
  endtask
  // Overrun interrupt once per flag, cleared with clear-overrun sent along with a release
  task automatic t_ovr();
    pulse(4'h2);
    pulse(4'h2);
    chk(n_ov, 1);
    apb(1'b1, CMD_ADDR, 8'h0C);
    apb(1'b0, STAT_ADDR, 8'h00);
    chk(rdv[1], 1'b0);
    chk(n_rel, 3);
    pulse(4'h2);
    chk(n_ov, 2);
  endtask
  // Transmit request, zero write, abort before and during a frame
  task automatic t_tx();
    apb(1'b1, CMD_ADDR, 8'h01);
    apb(1'b0, STAT_ADDR, 8'h00);
    chk(rdv[3], 1'b0);
    apb(1'b1, CMD_ADDR, 8'h00);
    chk(tx_go_o, 1'b1);
    apb(1'b1, CMD_ADDR, 8'h02);
    chk(tx_go_o, 1'b0);
    apb(1'b1, CMD_ADDR, 8'h01);
    pulse(4'h4);
    apb(1'b1, CMD_ADDR, 8'h02);
    @(posedge core_clk_i);
    tx_success_i <= 1'b1;
    pulse(4'h8);
    apb(1'b0, STAT_ADDR, 8'h00);
    chk(rdv[3], 1'b1);
  endtask
  // Refused sleep, clock run-out, bus wake, command wake
  task automatic t_sleep();
    @(posedge core_clk_i);
    irq_pending_i <= 1'b1;
    apb(1'b1, CMD_ADDR, 8'h10);
    chk({sleep_o, n_wk[1:0]}, 3'b001);
    @(posedge core_clk_i);
    irq_pending_i <= 1'b0;
    apb(1'b1, CMD_ADDR, 8'h10);
    chk(sleep_o, 1'b1);
    // Just short of 15 four-cycle bit times the clock must still run
    cyc(54);
    chk(osc_enable_o, 1'b1);
    cyc(26);
    chk({osc_enable_o, clock_output_pin_o}, 2'b00);
    @(posedge core_clk_i);
    bus_activity_i <= 1'b1;
    cyc(4);
    chk({sleep_o, osc_enable_o, rx_enable_o}, 3'b010);
    chk(n_wk, 2);
    @(posedge core_clk_i);
    bus_activity_i <= 1'b0;
    free(8'h01);
    chk(rx_enable_o, 1'b1);
    apb(1'b1, CMD_ADDR, 8'h10);
    apb(1'b1, CMD_ADDR, 8'h00);
    chk({sleep_o, n_wk[1:0]}, 3'b011);
    apb(1'b1, CMD_ADDR, 8'h10);
    chk(sleep_o, 1'b1);
    @(posedge core_clk_i);
    int_pin_low_i <= 1'b1;
    cyc(3);
    chk({sleep_o, n_wk[2:0]}, 4'b0100);
    @(posedge core_clk_i);
    int_pin_low_i <= 1'b0;
  endtask
  // Bus-off forces reset; 128 bus-free needed to go on
  task automatic t_busoff();
    @(posedge core_clk_i);
    bus_off_i <= 1'b1;
    cyc(4);
    chk({reset_mode_o, bus_on_o}, 2'b10);
    @(posedge core_clk_i);
    bus_off_i <= 1'b0;
    apb(1'b1, CTRL_ADDR, 8'h52);
    apb(1'b1, CMD_ADDR, 8'h10);
    chk(sleep_o, 1'b0);
    free(8'h7F);
    chk(bus_on_o, 1'b0);
    free(8'h01);
    chk(bus_on_o, 1'b1);
  endtask
  // Reset pin blocks clearing; legacy bit survives hardware reset
  task automatic t_pin();
    @(posedge core_clk_i);
    reset_pin_b_i <= 1'b0;
    apb(1'b1, CTRL_ADDR, 8'h52);
    apb(1'b0, CTRL_ADDR, 8'h00);
    chk(rdv[0], 1'b1);
    @(posedge core_clk_i);
    reset_pin_b_i <= 1'b1;
    apb(1'b1, CTRL_ADDR, 8'h52);
    apb(1'b0, CTRL_ADDR, 8'h00);
    chk(rdv[0], 1'b0);
    @(posedge core_clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    apb(1'b0, CTRL_ADDR, 8'h00);
    chk(rdv, 32'h0000_0061);
  endtask

  initial
  begin
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_start();
    t_rx();
    t_ovr();
    t_tx();
    t_sleep();
    t_busoff();
    t_pin();
    complete_run();
  end
endmodule // tb
